// file: hw/cprl_defines.svh
/*
  Register offsets, reset values, field positions and timing counts of the
  current and power result block.
  Assumes a 125 MHz system clock; included by bare name.
*/
`ifndef CPRL_DEFINES_SVH
`define CPRL_DEFINES_SVH

// Register offsets, byte addressed
`define CPRL_ADDR_VCFG 8'h50
`define CPRL_ADDR_CSCFG 8'h51
`define CPRL_ADDR_PEAK 8'h52
`define CPRL_ADDR_SH_HI 8'h54
`define CPRL_ADDR_SH_LO 8'h55
`define CPRL_ADDR_BUS_HI 8'h58
`define CPRL_ADDR_BUS_LO 8'h59
`define CPRL_ADDR_PWR_HI 8'h5B
`define CPRL_ADDR_PWR_LO 8'h5C
`define CPRL_ADDR_HILIM 8'h60
`define CPRL_ADDR_LOLIM 8'h61

// Reset values
`define CPRL_RST_VCFG 8'h80
`define CPRL_RST_CSCFG 8'h03
`define CPRL_RST_PEAK 8'h00
`define CPRL_RST_HILIM 8'h7F
`define CPRL_RST_LOLIM 8'h80

// Field positions
`define CPRL_PKSEL_BIT 7
`define CPRL_PWR_SHIFT 7

// Threshold and range scale, in mV and full-scale code
`define CPRL_TH_BASE_MV 10
`define CPRL_TH_STEP_MV 5
`define CPRL_RNG_BASE_MV 10
`define CPRL_FS_CODE 2047

// Timing: clock period and duration tick, in ns
`define CPRL_CLK_NS 8
`define CPRL_TICK_NS 10000
`define CPRL_TICK_CYCLES (`CPRL_TICK_NS / `CPRL_CLK_NS)

// Minimum spike durations in 10 us ticks, code 15 first (1 ms .. 4096 ms)
`define CPRL_DUR_TABLE {19'h64000, 19'h4B000, 19'h32000, 19'h25800, 19'h19000, \
  19'h12C00, 19'h0C800, 19'h09600, 19'h06400, 19'h03200, 19'h02800, 19'h01E00, \
  19'h01400, 19'h00A00, 19'h00200, 19'h00064}

`endif

// file: hw/cprl_pkg.sv
/*
  Types of the current and power result block: start-up states, result
  pair tags and the packed state of the top module.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cprl_pkg;

  // Start-up: two cycles fill the strap synchroniser, the third loads it
  typedef enum logic [1:0] {ST_WAIT0, ST_WAIT1, ST_WAIT2, ST_RUN} cprl_boot_e;

  // Which two-byte result the read shadow belongs to
  typedef enum logic [1:0] {PAIR_SHUNT, PAIR_BUS, PAIR_PWR} cprl_pair_e;

  typedef struct packed {
    cprl_boot_e boot;
    logic host_wr;
    logic [7:0] vcfg;
    logic [7:0] cscfg;
    logic [7:0] peak;
    logic [7:0] hilim;
    logic [7:0] lolim;
    logic [11:0] shunt;
    logic [10:0] bus;
    logic [15:0] pwr;
    logic hi_flag;
    logic lo_flag;
    logic [7:0] shadow;
    cprl_pair_e shadow_pair;
    logic shadow_vld;
    logic [7:0] rdata;
    logic ack;
    logic [18:0] dur_cnt;
    logic peak_det;
    logic alert_n;
    logic crit_n;
  } cprl_top_s;

endpackage : cprl_pkg

// file: hw/cprl_sync.sv
/*
  Two-flop synchroniser for the 8 strap pin levels.
  Assumes the pins are static levels; no logic reads the first stage.
*/
`timescale 1ns/1ns
module cprl_sync (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] d_i,
  output logic [7:0] q_o
);
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
  } cprl_sync_s;

  cprl_sync_s st_ff;
  cprl_sync_s nxt;

  // Second stage only ever sees the first
  always_comb begin
    nxt.s1 = d_i;
    nxt.s2 = st_ff.s1;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt;
    end
  end

  assign q_o = st_ff.s2;
endmodule : cprl_sync

// file: hw/cprl_tick_div.sv
/*
  Divider making a one-cycle enable pulse every TICK_CYCLES clocks.
  Assumes TICK_CYCLES is between 1 and 4096.
*/
`timescale 1ns/1ns
module cprl_tick_div #(
  parameter int TICK_CYCLES = 1250
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  cprl_tick_if.src tick_if
);
  typedef struct packed {
    logic [11:0] cnt;
    logic tick;
  } cprl_div_s;

  cprl_div_s st_ff;
  cprl_div_s nxt;

  // Free-running count; the pulse comes from a flop so it is glitch free
  always_comb begin
    nxt = st_ff;
    nxt.tick = (st_ff.cnt == 12'(TICK_CYCLES - 1));
    nxt.cnt = nxt.tick ? 12'h000 : st_ff.cnt + 12'h001;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt;
    end
  end

  assign tick_if.tick = st_ff.tick;
endmodule : cprl_tick_div

// file: hw/cprl_tick_if.sv
/*
  Carrier of the duration tick between the divider and the result block.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface cprl_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : cprl_tick_if

// file: hw/cprl_top.sv
/*
  Result and limit logic of a current and power monitor: peak detector
  settings and timer, shunt, bus and power results, shunt limit checks.
  Assumes a byte-wide register port driven by the serial management bus
  engine and a measurement front end, both on clk_i.
*/
`timescale 1ns/1ns
`include "cprl_defines.svh"
module cprl_top #(
  parameter int TICK_CYCLES = `CPRL_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port from the serial bus engine
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_ack_o,
  // Measurement front end
  input wire logic meas_valid_i,
  input wire logic [11:0] shunt_sample_i,
  input wire logic [11:0] bus_sample_i,
  input wire logic [11:0] inst_shunt_i,
  // Strap pins and alert setup
  input wire logic [3:0] threshold_strap_pin_i,
  input wire logic [3:0] duration_strap_pin_i,
  input wire logic alert_comp_mode_i,
  input wire logic flag_clear_i,
  // Status and alarm outputs
  output logic shunt_high_flag_o,
  output logic shunt_low_flag_o,
  output logic peak_detected_o,
  output logic alert_n_o,
  output logic critical_alarm_n_o
);

  localparam logic [303:0] DUR_TAB = `CPRL_DUR_TABLE;

  localparam cprl_pkg::cprl_top_s RST = '{
    boot: cprl_pkg::ST_WAIT0,
    host_wr: 1'b0,
    vcfg: `CPRL_RST_VCFG,
    cscfg: `CPRL_RST_CSCFG,
    peak: `CPRL_RST_PEAK,
    hilim: `CPRL_RST_HILIM,
    lolim: `CPRL_RST_LOLIM,
    shunt: 12'h000,
    bus: 11'h000,
    pwr: 16'h0000,
    hi_flag: 1'b0,
    lo_flag: 1'b0,
    shadow: 8'h00,
    shadow_pair: cprl_pkg::PAIR_SHUNT,
    shadow_vld: 1'b0,
    rdata: 8'h00,
    ack: 1'b0,
    dur_cnt: 19'h00000,
    peak_det: 1'b0,
    alert_n: 1'b1,
    crit_n: 1'b1
  };

  cprl_pkg::cprl_top_s st_ff;
  cprl_pkg::cprl_top_s nxt;

  logic [7:0] strap_sync;
  logic [6:0] thr_mv;
  logic [6:0] fs_mv;
  logic [17:0] lhs;
  logic [17:0] rhs;
  logic above;
  logic [18:0] dur_lim;
  logic [10:0] bus_clamped;
  logic signed [23:0] prod;
  logic [7:0] shunt_lo;
  logic [7:0] bus_lo;

  cprl_tick_if u_tick_if ();

  // Duration tick, one pulse every 10 us at the default setting
  cprl_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_div (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .tick_if(u_tick_if.src)
  );

  // Strap pins are outside the clock domain
  cprl_sync u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .d_i({threshold_strap_pin_i, duration_strap_pin_i}),
    .q_o(strap_sync)
  );

  // Threshold against the instantaneous shunt code, compared in mV*code
  // space so no divider is needed; only forward current can spike
  assign thr_mv = 7'(`CPRL_TH_BASE_MV + `CPRL_TH_STEP_MV * st_ff.peak[7:4]);
  assign fs_mv = 7'(`CPRL_RNG_BASE_MV << st_ff.cscfg[1:0]);
  assign lhs = 18'(inst_shunt_i[10:0]) * 18'(fs_mv);
  assign rhs = 18'(thr_mv) * 18'(`CPRL_FS_CODE);
  assign above = !inst_shunt_i[11] && (lhs > rhs);
  assign dur_lim = DUR_TAB[19 * st_ff.peak[3:0] +: 19];

  // Bus result has no sign, negative samples become zero
  assign bus_clamped = bus_sample_i[11] ? 11'h000 : bus_sample_i[10:0];
  assign prod = $signed(shunt_sample_i) * $signed({1'b0, bus_clamped});
  assign shunt_lo = {st_ff.shunt[3:0], 4'h0};
  assign bus_lo = {st_ff.bus[2:0], 5'h00};

  // Next state: start-up, writes, reads, results, limits, peak timer
  always_comb begin
    nxt = st_ff;
    nxt.ack = reg_rd_i | reg_wr_i;
    case (st_ff.boot)
      cprl_pkg::ST_WAIT0: begin
        nxt.boot = cprl_pkg::ST_WAIT1;
      end
      cprl_pkg::ST_WAIT1: begin
        nxt.boot = cprl_pkg::ST_WAIT2;
      end
      // Second synchroniser stage holds the strap level only from here on
      cprl_pkg::ST_WAIT2: begin
        nxt.boot = cprl_pkg::ST_RUN;
        // Straps only preset; a host write already made wins
        if (!st_ff.host_wr) begin
          nxt.peak = strap_sync;
        end
      end
      cprl_pkg::ST_RUN: begin
        nxt.boot = cprl_pkg::ST_RUN;
      end
      default: begin
        nxt.boot = cprl_pkg::ST_RUN;
      end
    endcase
    // Writes are taken in any state, result offsets drop the data
    if (reg_wr_i) begin
      case (reg_addr_i)
        `CPRL_ADDR_VCFG: nxt.vcfg = reg_wdata_i;
        `CPRL_ADDR_CSCFG: nxt.cscfg = reg_wdata_i;
        `CPRL_ADDR_PEAK: begin
          nxt.peak = reg_wdata_i;
          nxt.host_wr = 1'b1;
        end
        `CPRL_ADDR_HILIM: nxt.hilim = reg_wdata_i;
        `CPRL_ADDR_LOLIM: nxt.lolim = reg_wdata_i;
        default: nxt.host_wr = st_ff.host_wr;
      endcase
    end
    // A high-byte read parks the matching low byte in the shadow
    if (reg_rd_i) begin
      case (reg_addr_i)
        `CPRL_ADDR_VCFG: nxt.rdata = st_ff.vcfg;
        `CPRL_ADDR_CSCFG: nxt.rdata = st_ff.cscfg;
        `CPRL_ADDR_PEAK: nxt.rdata = st_ff.peak;
        `CPRL_ADDR_HILIM: nxt.rdata = st_ff.hilim;
        `CPRL_ADDR_LOLIM: nxt.rdata = st_ff.lolim;
        `CPRL_ADDR_SH_HI: begin
          nxt.rdata = st_ff.shunt[11:4];
          nxt.shadow = shunt_lo;
          nxt.shadow_pair = cprl_pkg::PAIR_SHUNT;
          nxt.shadow_vld = 1'b1;
        end
        `CPRL_ADDR_SH_LO: begin
          nxt.shadow_vld = 1'b0;
          nxt.rdata = (st_ff.shadow_vld && st_ff.shadow_pair == cprl_pkg::PAIR_SHUNT) ?
                      st_ff.shadow : shunt_lo;
        end
        `CPRL_ADDR_BUS_HI: begin
          nxt.rdata = st_ff.bus[10:3];
          nxt.shadow = bus_lo;
          nxt.shadow_pair = cprl_pkg::PAIR_BUS;
          nxt.shadow_vld = 1'b1;
        end
        `CPRL_ADDR_BUS_LO: begin
          nxt.shadow_vld = 1'b0;
          nxt.rdata = (st_ff.shadow_vld && st_ff.shadow_pair == cprl_pkg::PAIR_BUS) ?
                      st_ff.shadow : bus_lo;
        end
        `CPRL_ADDR_PWR_HI: begin
          nxt.rdata = st_ff.pwr[15:8];
          nxt.shadow = st_ff.pwr[7:0];
          nxt.shadow_pair = cprl_pkg::PAIR_PWR;
          nxt.shadow_vld = 1'b1;
        end
        `CPRL_ADDR_PWR_LO: begin
          nxt.shadow_vld = 1'b0;
          nxt.rdata = (st_ff.shadow_vld && st_ff.shadow_pair == cprl_pkg::PAIR_PWR) ?
                      st_ff.shadow : st_ff.pwr[7:0];
        end
        default: nxt.rdata = 8'h00;
      endcase
    end
    // Flags: a clear and a breach in one cycle keep the flag set
    if (flag_clear_i) begin
      nxt.hi_flag = 1'b0;
      nxt.lo_flag = 1'b0;
    end
    // All results load together, so they always belong to one update
    if (meas_valid_i) begin
      nxt.shunt = shunt_sample_i;
      nxt.bus = bus_clamped;
      nxt.pwr = prod[`CPRL_PWR_SHIFT +: 16];
      if ($signed(shunt_sample_i[11:4]) >= $signed(st_ff.hilim)) begin
        nxt.hi_flag = 1'b1;
      end
      if ($signed(shunt_sample_i[11:4]) < $signed(st_ff.lolim)) begin
        nxt.lo_flag = 1'b1;
      end
    end
    // Duration restarts whenever the level drops, saturates at the top
    if (!above) begin
      nxt.dur_cnt = 19'h00000;
    end else if (u_tick_if.tick && st_ff.dur_cnt != 19'h7FFFF) begin
      nxt.dur_cnt = st_ff.dur_cnt + 19'h00001;
    end
    nxt.peak_det = above && (nxt.dur_cnt >= dur_lim);
    // Spike goes to critical when selected, else to alert in comparator mode
    nxt.crit_n = !(nxt.peak_det && nxt.vcfg[`CPRL_PKSEL_BIT]);
    nxt.alert_n = !(nxt.hi_flag || nxt.lo_flag ||
                    (nxt.peak_det && !nxt.vcfg[`CPRL_PKSEL_BIT] && alert_comp_mode_i));
  end

  // State register; results come up zero
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= RST;
    end else begin
      st_ff <= nxt;
    end
  end

  // Outputs straight from flops
  assign reg_rdata_o = st_ff.rdata;
  assign reg_ack_o = st_ff.ack;
  assign shunt_high_flag_o = st_ff.hi_flag;
  assign shunt_low_flag_o = st_ff.lo_flag;
  assign peak_detected_o = st_ff.peak_det;
  assign alert_n_o = st_ff.alert_n;
  assign critical_alarm_n_o = st_ff.crit_n;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_hi_rd;
    reg_rd_i && reg_addr_i == `CPRL_ADDR_SH_HI;
  endsequence

  sequence s_lo_rd;
    reg_rd_i && reg_addr_i == `CPRL_ADDR_SH_LO;
  endsequence

  limit_high_a: assert property (
    meas_valid_i && !flag_clear_i && $signed(shunt_sample_i[11:4]) >= $signed(st_ff.hilim)
    |=> shunt_high_flag_o && !alert_n_o)
    else $error("high limit breach not flagged");

  limit_low_a: assert property (
    meas_valid_i && $signed(shunt_sample_i[11:4]) < $signed(st_ff.lolim)
    |=> shunt_low_flag_o && !alert_n_o)
    else $error("low limit breach not flagged");

  bus_clamp_a: assert property (
    meas_valid_i && bus_sample_i[11] |=> st_ff.bus == 11'h000)
    else $error("negative bus voltage not clamped");

  shunt_store_a: assert property (
    meas_valid_i |=> st_ff.shunt == $past(shunt_sample_i))
    else $error("shunt reading not stored");

  ro_write_a: assert property (
    reg_wr_i && (reg_addr_i == `CPRL_ADDR_PWR_HI || reg_addr_i == `CPRL_ADDR_PWR_LO) &&
    !meas_valid_i |=> $stable(st_ff.pwr))
    else $error("write changed a result register");

  shadow_read_a: assert property (
    s_hi_rd ##1 !reg_rd_i ##1 s_lo_rd
    |=> reg_rdata_o == {$past(st_ff.shunt[3:0], 3), 4'h0})
    else $error("low byte not from same update");

  peak_route_a: assert property (
    st_ff.peak_det |-> (critical_alarm_n_o == !st_ff.vcfg[`CPRL_PKSEL_BIT]))
    else $error("spike routed to wrong output");

  peak_restart_a: assert property (
    !above |=> !peak_detected_o && st_ff.dur_cnt == 19'h00000)
    else $error("spike timer not restarted");

  strap_load_a: assert property (
    st_ff.boot == cprl_pkg::ST_WAIT2 && !st_ff.host_wr && !reg_wr_i
    |=> st_ff.peak == $past(strap_sync))
    else $error("strap preset not loaded");

endmodule : cprl_top

// file: verification/cprl_host_model.sv
/*
  Register port master standing in for the serial bus engine.
  Assumes cprl_top on the same clock; requests change at the falling edge.
*/
`timescale 1ns/1ns
module cprl_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [7:0] rdata_i,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // Idle bus at time zero
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end

  // One request pulse, answer taken one cycle later; no idle state needed first
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic ok);
    @(negedge clk_i);
    rd_o = !w;
    wr_o = w;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    rd_o = 1'b0;
    wr_o = 1'b0;
    q = rdata_i;
    ok = (ack_i === 1'b1);
    // Released lines show garbage so a stale value cannot pass as held
    addr_o = ~a;
    wdata_o = ~d;
  endtask : access
endmodule : cprl_host_model

// file: verification/tb_top.sv
/*
  Self-checking bench of the current and power result block.
  Assumes the host model on the register port and a shortened duration tick.
*/
`timescale 1ns/1ns
module tb_top;
  localparam int TICKS = 2;
  logic clk_i, reset_n_i, rd, wr, ack, meas_valid_i, alert_comp_mode_i, flag_clear_i;
  logic [7:0] addr, wdata, rdata;
  logic [11:0] shunt_sample_i, bus_sample_i, inst_shunt_i;
  logic [3:0] th_pin, dur_pin;
  logic hi_f, lo_f, pk, alert_n, crit_n;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] m_hil, m_lol, old_lo;
  logic [11:0] m_sh;
  logic [10:0] m_bus;
  logic [15:0] m_pwr;
  int hist_q[$];
  logic [7:0] rst_a [11] = '{8'h60, 8'h61, 8'h54, 8'h55, 8'h58, 8'h59, 8'h5B, 8'h5C,
      8'h50, 8'h51, 8'h77};
  logic [7:0] rst_v [11] = '{8'h7F, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h80, 8'h03, 8'h00};

  cprl_host_model host_u (.clk_i(clk_i), .ack_i(ack), .rdata_i(rdata), .rd_o(rd),
      .wr_o(wr), .addr_o(addr), .wdata_o(wdata));

  cprl_top #(.TICK_CYCLES(TICKS)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .reg_ack_o(ack), .meas_valid_i(meas_valid_i),
      .shunt_sample_i(shunt_sample_i), .bus_sample_i(bus_sample_i),
      .inst_shunt_i(inst_shunt_i), .threshold_strap_pin_i(th_pin),
      .duration_strap_pin_i(dur_pin), .alert_comp_mode_i(alert_comp_mode_i),
      .flag_clear_i(flag_clear_i), .shunt_high_flag_o(hi_f), .shunt_low_flag_o(lo_f),
      .peak_detected_o(pk), .alert_n_o(alert_n), .critical_alarm_n_o(crit_n));

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Hang guard, well above the roughly 1800 cycles the sequence needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Read folds the acknowledge into the compare so a missing ack fails too
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic ok;
    host_u.access(1'b0, a, 8'h00, q, ok);
    chk({7'h00, ok, q}, {8'h01, e});
  endtask : rdchk

  task automatic wrreg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    host_u.access(1'b1, a, d, q, ok);
    chk({15'h0000, ok}, 16'h0001);
  endtask : wrreg

  // One result update; flag clear rides along so flags show only this sample
  task automatic meas(input logic [11:0] s, input logic [11:0] b);
    int sv, bv, hv;
    logic eh, el;
    sv = int'($signed(s));
    bv = ($signed(b) < 0) ? 0 : int'(b[10:0]);
    hv = sv >>> 4;
    eh = (hv >= int'($signed(m_hil)));
    el = (hv < int'($signed(m_lol)));
    hist_q.push_back(sv);
    m_sh = s;
    m_bus = bv[10:0];
    m_pwr = 16'((sv * bv) >>> 7);
    @(negedge clk_i);
    shunt_sample_i = s;
    bus_sample_i = b;
    meas_valid_i = 1'b1;
    flag_clear_i = 1'b1;
    @(negedge clk_i);
    meas_valid_i = 1'b0;
    flag_clear_i = 1'b0;
    chk({14'h0000, hi_f, lo_f}, {14'h0000, eh, el});
    if (eh || el) chk({15'h0000, alert_n}, 16'h0000);
  endtask : meas

  task automatic rd_results();
    rdchk(8'h54, m_sh[11:4]);
    rdchk(8'h55, {m_sh[3:0], 4'h0});
    rdchk(8'h58, m_bus[10:3]);
    rdchk(8'h59, {m_bus[2:0], 5'h00});
    rdchk(8'h5B, m_pwr[15:8]);
    rdchk(8'h5C, m_pwr[7:0]);
  endtask : rd_results

  task automatic peak_state(input int n, input logic [2:0] e);
    repeat (n) @(negedge clk_i);
    chk({13'h0000, pk, alert_n, crit_n}, {13'h0000, e});
  endtask : peak_state

  // Main sequence
  initial begin
    void'($urandom(61));
    reset_n_i = 1'b0;
    meas_valid_i = 1'b0;
    flag_clear_i = 1'b0;
    alert_comp_mode_i = 1'b0;
    shunt_sample_i = 12'h000;
    bus_sample_i = 12'h000;
    inst_shunt_i = 12'h000;
    th_pin = 4'h1;
    dur_pin = 4'h0;
    m_hil = 8'h7F;
    m_lol = 8'h80;
    repeat (3) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (5) @(negedge clk_i);
    rdchk(8'h52, 8'h10);
    for (int i = 0; i < 11; i++) rdchk(rst_a[i], rst_v[i]);
    wrreg(8'h54, 8'hFF);
    wrreg(8'h5C, 8'hFF);
    rdchk(8'h54, 8'h00);
    rdchk(8'h5C, 8'h00);
    // Random limits and samples; every fourth sample sits exactly on the high limit
    for (int i = 0; i < 24; i++) begin
      m_hil = 8'($urandom);
      m_lol = 8'($urandom);
      wrreg(8'h60, m_hil);
      wrreg(8'h61, m_lol);
      rdchk(8'h60, m_hil);
      if (i % 4 == 0) meas({m_hil, 4'($urandom)}, 12'($urandom));
      else meas(12'($urandom), 12'($urandom));
      rd_results();
    end
    // A new update between high and low read must not tear the pair
    rdchk(8'h54, m_sh[11:4]);
    old_lo = {4'(hist_q[$]), 4'h0};
    meas(12'($urandom), 12'h7FF);
    rdchk(8'h55, old_lo);
    rdchk(8'h55, {m_sh[3:0], 4'h0});
    // Threshold 15 mV at 80 mV range is code 384; 1 ms is 100 ticks
    m_hil = 8'h7F;
    m_lol = 8'h80;
    wrreg(8'h60, m_hil);
    wrreg(8'h61, m_lol);
    // Random limits may have left a sticky flag that would hold alert low
    @(negedge clk_i);
    flag_clear_i = 1'b1;
    @(negedge clk_i);
    flag_clear_i = 1'b0;
    chk({14'h0000, hi_f, lo_f}, 16'h0000);
    wrreg(8'h52, 8'h10);
    inst_shunt_i = 12'd383;
    peak_state(230, 3'b011);
    inst_shunt_i = 12'd384;
    repeat (150) @(negedge clk_i);
    inst_shunt_i = 12'd0;
    repeat (2) @(negedge clk_i);
    inst_shunt_i = 12'd384;
    peak_state(190, 3'b011);
    peak_state(20, 3'b110);
    inst_shunt_i = 12'd0;
    peak_state(3, 3'b011);
    wrreg(8'h50, 8'h00);
    alert_comp_mode_i = 1'b1;
    inst_shunt_i = 12'd384;
    peak_state(215, 3'b101);
    // 40 mV range moves the 15 mV threshold up to code 768
    inst_shunt_i = 12'd767;
    wrreg(8'h51, 8'h02);
    peak_state(215, 3'b011);
    inst_shunt_i = 12'd768;
    peak_state(215, 3'b101);
    final_report();
  end
endmodule : tb_top
